// file: atu_map.svh
// Bit positions, encodings, offsets and reset values of the accumulator transfer unit
`ifndef ATU_MAP_SVH
`define ATU_MAP_SVH

// ----------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------
`define ATU_F_COND 31:28
`define ATU_F_OPC 27:21
`define ATU_OPC_XFER 7'h62
`define ATU_F_DIR 20
`define ATU_F_HI 19:16
`define ATU_F_LO 15:12
`define ATU_F_CPN 11:8
`define ATU_CPN_ZERO 4'h0
`define ATU_F_SBZ 7:3
`define ATU_SBZ_ZERO 5'h00
`define ATU_F_SEL 2:0
`define ATU_SEL_ZERO 3'h0
`define ATU_DIR_IN 1'b0
`define ATU_DIR_OUT 1'b1
`define ATU_COND_NEVER 4'hF

// ----------------------------------------------------------------
// Accumulator layout
// ----------------------------------------------------------------
`define ATU_ACC_TOP 39:32
`define ATU_ACC_BOT 31:0
`define ATU_ACC_SIGN 39
`define ATU_SRC_BYTE 7:0
`define ATU_ACC_RST 40'h00_0000_0000
`define ATU_EXT_W 24

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define ATU_OFF_CTRL 4'h0
`define ATU_OFF_STAT 4'h4
`define ATU_OFF_ACC_LO 4'h8
`define ATU_OFF_ACC_HI 4'hC
`define ATU_CTRL_EN 0
`define ATU_CTRL_RST 1'b0
`define ATU_ST_SEL 0
`define ATU_ST_SBZ 1
`define ATU_ST_UNDEF 2
`define ATU_ST_RST 3'h0
`define ATU_F_STB 2:0
`define ATU_F_TOPB 7:0
`define ATU_ZERO32 32'h0000_0000

`endif

// file: atu_pkg.sv
// Types shared by the accumulator transfer unit
package atu_pkg;

  typedef struct packed {
    logic valid;
    logic [31:0] word;
    logic [3:0] flags;
    logic [31:0] src_hi;
    logic [31:0] src_lo;
  } atu_issue_t;

  typedef struct packed {
    logic wr_en;
    logic [3:0] hi_idx;
    logic [31:0] hi_data;
    logic [3:0] lo_idx;
    logic [31:0] lo_data;
    logic done;
    logic undef;
    logic [3:0] flags;
  } atu_result_t;

  typedef struct packed {
    logic [39:0] acc;
    atu_result_t res;
    logic access_en;
    logic [2:0] sticky;
    logic ack;
    logic [31:0] rdata;
  } atu_state_t;

endpackage

// file: atu_cond_check.sv
// Condition field evaluator against the N Z C V flags
`timescale 1ns/1ps
module atu_cond_check
  import atu_pkg::*;
(
  // Condition and flags, flags ordered N Z C V
  input wire logic [3:0] cond,
  input wire logic [3:0] flags,
  // Result
  output logic pass
);
  logic n, z, c, v;

  always_comb begin
    n = flags[3];
    z = flags[2];
    c = flags[1];
    v = flags[0];
    unique case (cond)
      4'h0: pass = z;
      4'h1: pass = !z;
      4'h2: pass = c;
      4'h3: pass = !c;
      4'h4: pass = n;
      4'h5: pass = !n;
      4'h6: pass = v;
      4'h7: pass = !v;
      4'h8: pass = c && !z;
      4'h9: pass = !c || z;
      4'hA: pass = (n == v);
      4'hB: pass = (n != v);
      4'hC: pass = !z && (n == v);
      4'hD: pass = z || (n != v);
      4'hE: pass = 1'b1;
      4'hF: pass = 1'b0;
    endcase
  end
endmodule

// file: atu_transfer_unit.sv
// Accumulator transfer unit: moves between a register pair and the 40-bit accumulator
//
// Summary of operation
// RL1 - Decode coprocessor transfers, condition in top bits
// RL2 - Direction bit: zero in, one out
// RL3 - Upper and lower register numbers from fields
// RL4 - Move in: low word, upper byte loaded
// RL5 - Move out: low word, sign-extended top byte
// RL6 - Exactly one 40-bit accumulator
// RL7 - Three-bit selector names one of eight
// RL8 - Software selects only accumulator zero
// RL9 - Software keeps reserved bits zero
// RL10 - Allowed any mode when access bit set
// RL11 - Access bit clear: undefined, nothing changes
// RL12 - Failed condition means no effect
// RL13 - Condition flags never changed
// RL14 - Software never names one register twice
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "atu_map.svh"
module atu_transfer_unit
  import atu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction issue from decode
  input wire atu_issue_t issue,
  // Register write-back and completion
  output atu_result_t result,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  atu_state_t state_ff;
  atu_state_t nxt_state;
  logic is_xfer;
  logic cond_pass;
  logic dir;
  logic exec;
  logic bus_req;
  logic bus_wr;

  assign is_xfer = issue.valid && (issue.word[`ATU_F_OPC] == `ATU_OPC_XFER)
                   && (issue.word[`ATU_F_CPN] == `ATU_CPN_ZERO); // [RL1]
  assign dir = issue.word[`ATU_F_DIR]; // [RL2]
  assign exec = is_xfer && state_ff.access_en && cond_pass; // [RL10] [RL12]
  assign bus_req = wb_cyc_i && wb_stb_i && !state_ff.ack;
  assign bus_wr = wb_cyc_i && wb_stb_i && state_ff.ack && wb_we_i;

  atu_cond_check u_cond (
    .cond(issue.word[`ATU_F_COND]),
    .flags(issue.flags),
    .pass(cond_pass)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.res.wr_en = 1'b0;
    nxt_state.res.done = 1'b0;
    nxt_state.res.undef = 1'b0;
    nxt_state.res.flags = issue.flags; // [RL13]
    nxt_state.ack = bus_req;
    nxt_state.rdata = `ATU_ZERO32;

    // Register reads, captured as ack rises
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `ATU_OFF_CTRL: nxt_state.rdata[`ATU_CTRL_EN] = state_ff.access_en;
        `ATU_OFF_STAT: nxt_state.rdata[`ATU_F_STB] = state_ff.sticky;
        `ATU_OFF_ACC_LO: nxt_state.rdata = state_ff.acc[`ATU_ACC_BOT];
        `ATU_OFF_ACC_HI: nxt_state.rdata[`ATU_F_TOPB] = state_ff.acc[`ATU_ACC_TOP];
        default: nxt_state.rdata = `ATU_ZERO32;
      endcase
    end

    // Register writes take effect at the edge the master sees ack
    if (bus_wr && wb_sel_i[0]) begin
      if (wb_adr_i == `ATU_OFF_CTRL) begin
        nxt_state.access_en = wb_dat_i[`ATU_CTRL_EN];
      end
      if (wb_adr_i == `ATU_OFF_STAT) begin
        nxt_state.sticky = state_ff.sticky & ~wb_dat_i[`ATU_F_STB];
      end
    end

    // Sticky hazards, set wins over clear
    if (is_xfer && (issue.word[`ATU_F_SEL] != `ATU_SEL_ZERO)) begin
      nxt_state.sticky[`ATU_ST_SEL] = 1'b1; // [RL7] [RL8]
    end
    if (is_xfer && (issue.word[`ATU_F_SBZ] != `ATU_SBZ_ZERO)) begin
      nxt_state.sticky[`ATU_ST_SBZ] = 1'b1; // [RL9]
    end

    // Transfer
    if (is_xfer && !state_ff.access_en) begin
      nxt_state.res.undef = 1'b1; // [RL11]
      nxt_state.sticky[`ATU_ST_UNDEF] = 1'b1;
    end else if (is_xfer) begin
      nxt_state.res.done = 1'b1;
    end
    if (exec) begin
      if (dir == `ATU_DIR_IN) begin
        nxt_state.acc = {issue.src_hi[`ATU_SRC_BYTE], issue.src_lo}; // [RL4] [RL6]
      end else begin
        nxt_state.res.wr_en = 1'b1;
        nxt_state.res.hi_idx = issue.word[`ATU_F_HI]; // [RL3]
        nxt_state.res.lo_idx = issue.word[`ATU_F_LO]; // [RL3]
        nxt_state.res.lo_data = state_ff.acc[`ATU_ACC_BOT]; // [RL5]
        nxt_state.res.hi_data = {{`ATU_EXT_W{state_ff.acc[`ATU_ACC_SIGN]}},
                                 state_ff.acc[`ATU_ACC_TOP]}; // [RL5]
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.acc <= `ATU_ACC_RST;
      state_ff.access_en <= `ATU_CTRL_RST;
      state_ff.sticky <= `ATU_ST_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign result = state_ff.res;
  assign wb_dat_o = state_ff.rdata;
  assign wb_ack_o = state_ff.ack;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_move_in;
    exec && (dir == `ATU_DIR_IN);
  endsequence

  sequence s_move_out;
    exec && (dir == `ATU_DIR_OUT);
  endsequence

  sequence s_wb_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  AST_NOT_XFER: assert property (@(posedge clk) disable iff (rst) // [RL1]
    (issue.valid && (issue.word[`ATU_F_OPC] != `ATU_OPC_XFER))
      |=> !result.done && !result.undef && !result.wr_en)
    else $error("Non-transfer word acted on");

  AST_MOVE_IN: assert property (@(posedge clk) disable iff (rst) // [RL4]
    s_move_in |=> (state_ff.acc == {$past(issue.src_hi[`ATU_SRC_BYTE]), $past(issue.src_lo)}) && !result.wr_en)
    else $error("Move in loaded wrong value");

  AST_MOVE_OUT: assert property (@(posedge clk) disable iff (rst) // [RL5]
    s_move_out |=> result.wr_en && (result.lo_data == $past(state_ff.acc[`ATU_ACC_BOT]))
      && (result.hi_data == {{`ATU_EXT_W{$past(state_ff.acc[`ATU_ACC_SIGN])}}, $past(state_ff.acc[`ATU_ACC_TOP])})
      && $stable(state_ff.acc))
    else $error("Move out data wrong");

  AST_INDEX: assert property (@(posedge clk) disable iff (rst) // [RL3]
    s_move_out |=> (result.hi_idx == $past(issue.word[`ATU_F_HI]))
      && (result.lo_idx == $past(issue.word[`ATU_F_LO])))
    else $error("Register numbers wrong");

  AST_UNDEF: assert property (@(posedge clk) disable iff (rst) // [RL11]
    (is_xfer && !state_ff.access_en) |=> result.undef && !result.done && !result.wr_en && $stable(state_ff.acc))
    else $error("Disabled transfer not undefined");

  AST_COND_FAIL: assert property (@(posedge clk) disable iff (rst) // [RL12]
    (is_xfer && state_ff.access_en && !cond_pass) |=> result.done && !result.wr_en && $stable(state_ff.acc))
    else $error("Failed condition had effect");

  AST_FLAGS: assert property (@(posedge clk) disable iff (rst) // [RL13]
    is_xfer |=> (result.flags == $past(issue.flags)))
    else $error("Flags altered");

  AST_SEL_SEEN: assert property (@(posedge clk) disable iff (rst) // [RL7]
    (is_xfer && (issue.word[`ATU_F_SEL] != `ATU_SEL_ZERO)) |=> state_ff.sticky[`ATU_ST_SEL])
    else $error("Nonzero selector not recorded");

  AST_SBZ_SEEN: assert property (@(posedge clk) disable iff (rst) // [RL9]
    (is_xfer && (issue.word[`ATU_F_SBZ] != `ATU_SBZ_ZERO)) |=> state_ff.sticky[`ATU_ST_SBZ])
    else $error("Reserved bits not recorded");

  AST_UNDEF_SEEN: assert property (@(posedge clk) disable iff (rst) // [RL11]
    (is_xfer && !state_ff.access_en) |=> state_ff.sticky[`ATU_ST_UNDEF])
    else $error("Undefined transfer not recorded");

  AST_QUIET: assert property (@(posedge clk) disable iff (rst) // [RL1]
    !is_xfer |=> !result.done && !result.undef && !result.wr_en)
    else $error("Output pulse without transfer");

  AST_ACC_HOLD: assert property (@(posedge clk) disable iff (rst) // [RL6]
    !(exec && (dir == `ATU_DIR_IN)) |=> $stable(state_ff.acc))
    else $error("Accumulator changed without move in");

  AST_WR_DONE: assert property (@(posedge clk) disable iff (rst) // [RL12]
    result.wr_en |-> result.done && !result.undef)
    else $error("Write without accepted transfer");

  AST_COND_NEVER: assert property (@(posedge clk) disable iff (rst) // [RL12]
    (is_xfer && (issue.word[`ATU_F_COND] == `ATU_COND_NEVER)) |=> !result.wr_en && $stable(state_ff.acc))
    else $error("Never condition had effect");

  // ----------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------
  sequence s_rd_lo;
    bus_req && !wb_we_i && (wb_adr_i == `ATU_OFF_ACC_LO);
  endsequence

  sequence s_rd_hi;
    bus_req && !wb_we_i && (wb_adr_i == `ATU_OFF_ACC_HI);
  endsequence

  sequence s_wr_ctrl;
    bus_wr && wb_sel_i[0] && (wb_adr_i == `ATU_OFF_CTRL);
  endsequence

  AST_RD_LO: assert property (@(posedge clk) disable iff (rst) // [RL6]
    s_rd_lo |=> wb_ack_o && (wb_dat_o == $past(state_ff.acc[`ATU_ACC_BOT])))
    else $error("Low accumulator read wrong");

  AST_RD_HI: assert property (@(posedge clk) disable iff (rst) // [RL6]
    s_rd_hi |=> wb_ack_o && (wb_dat_o == {{`ATU_EXT_W{1'b0}}, $past(state_ff.acc[`ATU_ACC_TOP])}))
    else $error("Top accumulator read wrong");

  AST_WR_CTRL: assert property (@(posedge clk) disable iff (rst) // [RL10]
    s_wr_ctrl |=> (state_ff.access_en == $past(wb_dat_i[`ATU_CTRL_EN])))
    else $error("Access bit write lost");

  AST_ACK_IDLE: assert property (@(posedge clk) disable iff (rst)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("Ack without request");

  AST_RD_IDLE: assert property (@(posedge clk) disable iff (rst)
    !wb_ack_o |-> (wb_dat_o == `ATU_ZERO32))
    else $error("Read data outside ack");

  AST_WB_ACK: assert property (@(posedge clk) disable iff (rst)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> s_wb_ack_pulse)
    else $error("Bus ack not a single pulse");

endmodule

// file: atu_regfile_model.sv
// Pipeline and general register file model facing the accumulator transfer unit
`timescale 1ns/1ps
module atu_regfile_model
  import atu_pkg::*;
(
  // Clock
  input wire logic clk,
  // Preload port
  input wire logic ld,
  input wire logic [3:0] ld_idx,
  input wire logic [31:0] ld_val,
  // Instruction and write-back
  input wire logic [31:0] word,
  input wire atu_result_t result,
  // Source operands
  output logic [31:0] src_hi,
  output logic [31:0] src_lo
);
  logic [31:0] regs [16];
  assign src_hi = regs[word[19:16]];
  assign src_lo = regs[word[15:12]];
  always @(posedge clk) begin
    if (ld) begin
      regs[ld_idx] <= ld_val;
    end
    if (result.wr_en) begin
      regs[result.lo_idx] <= result.lo_data;
      regs[result.hi_idx] <= result.hi_data;
    end
  end
endmodule

// file: tb_accumulator_transfer_unit.sv
// Self-checking bench for the accumulator transfer unit
`timescale 1ns/1ps
module tb_accumulator_transfer_unit;
  import atu_pkg::*;
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, ld = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [3:0] flg = 4'h0, adr = 4'h0, sel = 4'h0, ld_idx = 4'h0;
  logic [31:0] word = 32'h0, dat = 32'h0, ld_val = 32'h0, m_hi, m_lo, rdat;
  atu_issue_t iss;
  atu_result_t result;
  int errors = 0, n_compared = 0, cycles = 0;
  assign iss = {vld, word, flg, m_hi, m_lo};
  atu_transfer_unit i_dut(.clk(clk), .rst(rst), .issue(iss), .result(result), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack));
  atu_regfile_model i_rf(.clk(clk), .ld(ld), .ld_idx(ld_idx), .ld_val(ld_val), .word(word), .result(result),
    .src_hi(m_hi), .src_lo(m_lo));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] mk(logic [3:0] c, logic d, logic [3:0] h, logic [3:0] l, logic [2:0] s);
    return {c, 7'h62, d, h, l, 4'h0, 5'h00, s};
  endfunction
  function automatic logic cpass(logic [3:0] c, logic [3:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = f[3] == f[0];
      3'h6: r = ~f[2] & (f[3] == f[0]);
      default: r = 1'b1;
    endcase
    return (c == 4'hF) ? 1'b0 : r ^ c[0];
  endfunction
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wrr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic pre(input logic [3:0] i, input logic [31:0] v);
    @(posedge clk);
    ld <= 1'b1;
    ld_idx <= i;
    ld_val <= v;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  task automatic xfer(input logic [31:0] w, input logic [3:0] f, input logic [2:0] exp);
    vld <= 1'b1;
    word <= w;
    flg <= f;
    @(posedge clk);
    vld <= 1'b0;
    @(posedge clk);
    chk({result.done, result.undef, result.wr_en}, exp);
    chk(result.flags, f);
  endtask
  task automatic idle();
    vld <= 1'b0;
    @(posedge clk);
    chk({result.done, result.undef, result.wr_en}, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(4'h0, 32'h0);
    rdc(4'h8, 32'h0);
    rdc(4'hC, 32'h0);
    rdc(4'h2, 32'h0);
    $display("test reset done");
    pre(4'h2, 32'h1234_56A5);
    pre(4'h3, 32'h8765_4321);
    pre(4'h6, 32'h0000_007F);
    xfer(mk(4'hE, 1'b0, 4'h2, 4'h3, 3'h0), 4'h6, 3'h2);
    idle();
    rdc(4'h8, 32'h0);
    rdc(4'h4, 32'h4);
    wrr(4'h4, 32'h4);
    rdc(4'h4, 32'h0);
    $display("test access disabled done");
    wrr(4'h0, 32'h1);
    xfer(mk(4'hE, 1'b0, 4'h2, 4'h3, 3'h0), 4'h6, 3'h4);
    xfer(mk(4'hE, 1'b1, 4'h4, 4'h5, 3'h0), 4'h9, 3'h5);
    chk(result.lo_data, 32'h8765_4321);
    chk(result.hi_data, 32'hFFFF_FFA5);
    chk({result.hi_idx, result.lo_idx}, 32'h45);
    idle();
    rdc(4'h8, 32'h8765_4321);
    rdc(4'hC, 32'hA5);
    xfer(mk(4'hE, 1'b0, 4'h6, 4'h3, 3'h0), 4'h6, 3'h4);
    xfer(mk(4'hE, 1'b1, 4'h7, 4'h8, 3'h0), 4'h6, 3'h5);
    chk(result.hi_data, 32'h0000_007F);
    $display("test transfers done");
    for (int k = 0; k < 32; k++) begin
      xfer(mk(4'(k), 1'b1, 4'h4, 4'h5, 3'h0), k[4] ? 4'h9 : 4'h6, {2'h2, cpass(4'(k), k[4] ? 4'h9 : 4'h6)});
    end
    xfer(mk(4'h0, 1'b0, 4'h2, 4'h3, 3'h0), 4'h0, 3'h4);
    xfer(mk(4'hE, 1'b0, 4'h2, 4'h3, 3'h0) ^ 32'h0000_0100, 4'h6, 3'h0);
    xfer(mk(4'hE, 1'b0, 4'h2, 4'h3, 3'h0) ^ 32'h0020_0000, 4'h6, 3'h0);
    idle();
    rdc(4'hC, 32'h7F);
    $display("test conditions and decode done");
    xfer(mk(4'hE, 1'b0, 4'h2, 4'h3, 3'h7), 4'h6, 3'h4);
    xfer(mk(4'hE, 1'b1, 4'h4, 4'h5, 3'h0) | 32'h80, 4'h6, 3'h5);
    idle();
    rdc(4'hC, 32'hA5);
    rdc(4'h4, 32'h3);
    wrr(4'h4, 32'h7);
    rdc(4'h4, 32'h0);
    $display("test selector done");
    tally_and_finish();
  end
endmodule
